// File: core/cfgp_pkg.sv
// Purpose: Shared constants for the configuration and host port pin block.
// Assumes: System clock of 100 MHz; link clocks sampled as plain inputs.
// Notes:   Mode encodings are internal choices of this block.
package cfgp_pkg;
  localparam int          CFGP_DATA_W     = 8;
  localparam int          CFGP_FIFO_DEPTH = 16;
  localparam int          CFGP_ADDR_W     = 5;
  localparam int          CFGP_SER_BIT    = 0;
  localparam logic [2:0]  CFGP_BIT_LAST   = 3'h7;
  localparam logic [2:0]  CFGP_BIT_FIRST  = 3'h0;
  localparam logic [7:0]  CFGP_PULLUP_ALL = 8'hFF;
  localparam logic [7:0]  CFGP_BYTE_ZERO  = 8'h00;
  localparam logic [4:0]  CFGP_ADDR_ZERO  = 5'h00;
  localparam logic [1:0]  CFGP_BE_OFF     = 2'h3;

  typedef enum logic [2:0] {
    CFGP_MODE_SLAVE_SERIAL,
    CFGP_MODE_MASTER_SERIAL,
    CFGP_MODE_MASTER_PARALLEL,
    CFGP_MODE_PERIPHERAL,
    CFGP_MODE_SLAVE_PARALLEL,
    CFGP_MODE_HOST_START,
    CFGP_MODE_HOST_MUX
  } cfgp_mode_type;

  typedef enum logic [1:0] {
    CFGP_ST_IDLE,
    CFGP_ST_CONFIG,
    CFGP_ST_USER
  } cfgp_state_type;
endpackage

// File: core/cfgp_fifo.sv
// Purpose: Configuration byte FIFO with valid and ready on both sides.
// Assumes: Single clock; synchronous active-low reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module cfgp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,   // System clock.
  input  wire logic             reset_n,   // Synchronous reset, low.
  input  wire logic [WIDTH-1:0] in_data,   // Write data.
  input  wire logic             in_valid,  // Write request.
  output logic                  in_ready,  // Space available.
  output logic      [WIDTH-1:0] out_data,  // Head word.
  output logic                  out_valid, // Head word present.
  input  wire logic             out_ready  // Consumer takes head.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  wire              full = (wr_q[AW] != rd_q[AW]) &&
                           (wr_q[AW-1:0] == rd_q[AW-1:0]);

  assign in_ready  = ~full;
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// File: core/cfgp_pins.sv
// Purpose: Configuration data pins and host processor port pin logic.
// Assumes: cfg_clock and host_port_clock are sampled by clk_sys.
// Notes:   Pin wires are resolved outside from the enable outputs.
//
// How it works
// - Serial modes shift data in on each rising configuration clock edge while the FIFO has space.
// - Daisy-chain output driven in configuration, changes on falling clock.
// - Parallel modes take whole bytes from data pins, all pulled up.
// - Serial input and data bit zero are one and the same pin.
// - Serial input pin has pull-up enabled while configuring.
// - Host port samples the host port clock input for its timing.
// - Transfer-start style takes five address pins, pin four as the MSB.
// - Multiplexed style takes address bits four down to two from data pins four down to two.
// - Multiplexed style uses inverted byte enables as address bits one, zero.
// - Data pins carry data or multiplexed address/data by style.
// - After configuration, host pins return to user I/O when port unused.
`timescale 1ns/1ps
`default_nettype none
module cfgp_pins
  import cfgp_pkg::*;
(
  input  wire logic                  clk_sys,          // System clock.
  input  wire logic                  reset_n,          // Sync reset, low.
  input  wire cfgp_pkg::cfgp_mode_type mode,           // Configuration mode.
  input  wire logic                  cfg_start,        // Begin configuring.
  input  wire logic                  cfg_done,         // Configuration over.
  input  wire logic                  host_port_used,   // Host port in use.
  input  wire logic                  cfg_clock,        // Config clock pin.
  input  wire logic [7:0]            data_pin_in,      // Data pins, D0 = DIN.
  input  wire logic                  data_strobe,      // Parallel byte strobe.
  input  wire logic [4:0]            addr_pin_in,      // Address pins.
  input  wire logic [1:0]            host_byte_enable_n, // Byte enables, low.
  input  wire logic                  host_port_clock,  // Host port clock pin.
  input  wire logic                  host_addr_strobe, // Host address phase.
  output logic [7:0]                 data_pullup,      // Data pin pull-ups.
  output logic                       dout_out,         // Daisy-chain data.
  output logic                       dout_oe,          // Daisy-chain enable.
  output logic                       host_pins_user,   // Host pins as user I/O.
  output logic [4:0]                 host_addr,        // Mapped host address.
  output logic                       host_addr_valid,  // Address captured.
  output logic [7:0]                 host_data,        // Host data byte.
  output logic                       host_data_valid,  // Data captured.
  output logic [7:0]                 cfg_byte,         // Configuration byte.
  output logic                       cfg_byte_valid,   // Byte available.
  input  wire logic                  cfg_byte_ready,   // Consumer ready.
  output logic                       cfg_stall         // FIFO full.
);
  import cfgp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detection.
  logic [1:0] cfg_clock_sync_q;
  logic [1:0] hclk_sync_q;
  logic       cfg_clock_prev_q;
  logic       hclk_prev_q;
  logic [7:0] data_s1_q;
  logic [7:0] data_s2_q;
  logic [4:0] addr_s1_q;
  logic [4:0] addr_s2_q;
  logic [1:0] be_s1_q;
  logic [1:0] be_s2_q;
  logic [1:0] ctl_s1_q;
  logic [1:0] ctl_s2_q;

  always_ff @(posedge clk_sys) begin
    cfg_clock_sync_q <= {cfg_clock_sync_q[0], cfg_clock};
    hclk_sync_q <= {hclk_sync_q[0], host_port_clock};
    data_s1_q   <= data_pin_in;
    data_s2_q   <= data_s1_q;
    addr_s1_q   <= addr_pin_in;
    addr_s2_q   <= addr_s1_q;
    be_s1_q     <= host_byte_enable_n;
    be_s2_q     <= be_s1_q;
    ctl_s1_q    <= {host_addr_strobe, data_strobe};
    ctl_s2_q    <= ctl_s1_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg_clock_prev_q <= 1'b0;
      hclk_prev_q <= 1'b0;
    end else begin
      cfg_clock_prev_q <= cfg_clock_sync_q[1];
      hclk_prev_q <= hclk_sync_q[1];
    end
  end

  wire cfg_clock_rise = cfg_clock_sync_q[1] & ~cfg_clock_prev_q;
  wire cfg_clock_fall = ~cfg_clock_sync_q[1] & cfg_clock_prev_q;
  wire hclk_rise = hclk_sync_q[1] & ~hclk_prev_q;
  wire ser_in    = data_s2_q[CFGP_SER_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Phase control.
  cfgp_state_type state_q;
  cfgp_state_type state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      CFGP_ST_IDLE:   if (cfg_start) state_d = CFGP_ST_CONFIG;
      CFGP_ST_CONFIG: if (cfg_done)  state_d = CFGP_ST_USER;
      CFGP_ST_USER:   if (cfg_start) state_d = CFGP_ST_CONFIG;
      default:        state_d = CFGP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) state_q <= CFGP_ST_IDLE;
    else          state_q <= state_d;
  end

  wire in_cfg     = (state_q == CFGP_ST_CONFIG);
  wire in_user    = (state_q == CFGP_ST_USER);
  wire mode_ser   = (mode == CFGP_MODE_SLAVE_SERIAL) ||
                    (mode == CFGP_MODE_MASTER_SERIAL);
  wire mode_par   = (mode == CFGP_MODE_MASTER_PARALLEL) ||
                    (mode == CFGP_MODE_PERIPHERAL) ||
                    (mode == CFGP_MODE_SLAVE_PARALLEL);
  wire mode_start = (mode == CFGP_MODE_HOST_START);
  wire mode_mux   = (mode == CFGP_MODE_HOST_MUX);

  // Only bit zero doubles as serial input, so while configuring outside the parallel modes it alone keeps its pull-up.
  assign data_pullup = !in_cfg   ? CFGP_BYTE_ZERO :
                       mode_par  ? CFGP_PULLUP_ALL :
                       {{(CFGP_DATA_W-1){1'b0}}, 1'b1};
  assign host_pins_user = in_user & ~host_port_used;

  //////////////////////////////////////////////////////////////////////////
  // Serial shifting and daisy-chain output.
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic       dout_q;
  logic       par_prev_q;
  logic [7:0] push_data_q;
  logic       push_q;
  wire        fifo_ready;
  wire        ser_take = in_cfg & mode_ser & cfg_clock_rise & fifo_ready;
  wire        par_take = in_cfg & mode_par & ctl_s2_q[0] & ~par_prev_q;
  wire [7:0]  shift_d  = {shift_q[6:0], ser_in};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shift_q     <= CFGP_BYTE_ZERO;
      bit_q       <= CFGP_BIT_FIRST;
      dout_q      <= 1'b0;
      par_prev_q  <= 1'b0;
      push_q      <= 1'b0;
      push_data_q <= CFGP_BYTE_ZERO;
    end else begin
      par_prev_q <= ctl_s2_q[0];
      push_q     <= 1'b0;
      if (ser_take) begin
        shift_q <= shift_d;
        bit_q   <= bit_q + 3'h1;
        if (bit_q == CFGP_BIT_LAST) begin
          push_q      <= 1'b1;
          push_data_q <= shift_d;
        end
      end
      if (in_cfg & cfg_clock_fall) dout_q <= shift_q[7];
      if (par_take) begin
        push_q      <= 1'b1;
        push_data_q <= data_s2_q;
      end
      if (!in_cfg) bit_q <= CFGP_BIT_FIRST;
    end
  end

  assign dout_out   = dout_q;
  assign dout_oe    = in_cfg;
  assign cfg_stall  = ~fifo_ready;

  cfgp_fifo #(
    .WIDTH (CFGP_DATA_W),
    .DEPTH (CFGP_FIFO_DEPTH)
  ) cfgp_fifo_i (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_data   (push_data_q),
    .in_valid  (push_q),
    .in_ready  (fifo_ready),
    .out_data  (cfg_byte),
    .out_valid (cfg_byte_valid),
    .out_ready (cfg_byte_ready)
  );

  //////////////////////////////////////////////////////////////////////////
  // Host processor port capture on host clock rising edges.
  wire        host_on = (in_cfg & (mode_start | mode_mux)) |
                        (in_user & host_port_used);
  // Host numbering runs the other way, so pin four, host bit 27, is the MSB.
  wire [CFGP_ADDR_W-1:0] addr_map = addr_s2_q;
  wire [1:0]  addr_low = ~be_s2_q;
  logic [4:0] haddr_q;
  logic [7:0] hdata_q;
  logic       hav_q;
  logic       hdv_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      haddr_q <= CFGP_ADDR_ZERO;
      hdata_q <= CFGP_BYTE_ZERO;
      hav_q   <= 1'b0;
      hdv_q   <= 1'b0;
    end else begin
      hav_q <= 1'b0;
      hdv_q <= 1'b0;
      if (host_on & hclk_rise) begin
        if (mode_start) begin
          haddr_q <= addr_map;
          hdata_q <= data_s2_q;
          hav_q   <= ctl_s2_q[1];
          hdv_q   <= 1'b1;
        end else if (ctl_s2_q[1]) begin
          haddr_q <= {data_s2_q[4:2], addr_low};
          hav_q   <= 1'b1;
        end else begin
          hdata_q <= data_s2_q;
          hdv_q   <= 1'b1;
        end
      end
    end
  end

  assign host_addr       = haddr_q;
  assign host_addr_valid = hav_q;
  assign host_data       = hdata_q;
  assign host_data_valid = hdv_q;
endmodule
`default_nettype wire

// File: sim/cfgp_pins_properties.sv
// Purpose: Port-level checks for the configuration pin block.
// Assumes: Host pins stay still while a host capture is flagged.
// Notes:   Bound to every cfgp_pins instance.
`timescale 1ns/1ps
`default_nettype none
module cfgp_pins_properties
  import cfgp_pkg::*;
(
  input wire logic       clk_sys, reset_n, cfg_clock, // Clock, reset.
  input wire cfgp_pkg::cfgp_mode_type mode,           // Mode.
  input wire logic [7:0] data_pin_in, data_pullup, cfg_byte, // Bytes.
  input wire logic [4:0] addr_pin_in, host_addr,      // Addresses.
  input wire logic [1:0] host_byte_enable_n,          // Byte enables.
  input wire logic       host_port_used, cfg_byte_ready, // Inputs.
  input wire logic       dout_out, dout_oe, host_pins_user, // Pins.
  input wire logic       host_addr_valid, host_data_valid, // Host.
  input wire logic       cfg_byte_valid, cfg_stall    // Stream.
);
  import cfgp_pkg::*;
  logic par_mode;
  assign par_mode = (mode == CFGP_MODE_MASTER_PARALLEL) ||
                    (mode == CFGP_MODE_PERIPHERAL) ||
                    (mode == CFGP_MODE_SLAVE_PARALLEL);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  a_config_drive: assert property (
    dout_oe == (data_pullup != CFGP_BYTE_ZERO)) else $error("drive mismatch");
  a_parallel_pullups: assert property (
    dout_oe && par_mode |-> data_pullup == CFGP_PULLUP_ALL)
    else $error("parallel pull-ups wrong");
  a_serial_pullup: assert property (
    dout_oe && !par_mode |-> data_pullup == 8'h01)
    else $error("serial pull-up wrong");
  a_user_release: assert property (
    host_pins_user |-> !dout_oe && !host_port_used)
    else $error("pins released wrongly");
  a_dout_fall_only: assert property (
    dout_oe && $changed(dout_out) |-> !$past(cfg_clock) && !$past(cfg_clock, 2))
    else $error("daisy output moved off falling edge");
  a_start_addr_map: assert property (
    host_addr_valid && mode == CFGP_MODE_HOST_START |-> host_addr ==
    addr_pin_in) else $error("start address order wrong");
  a_mux_addr_map: assert property (
    host_addr_valid && mode == CFGP_MODE_HOST_MUX |-> host_addr ==
    {data_pin_in[4:2], ~host_byte_enable_n}) else $error("mux address wrong");
  a_host_pulse: assert property (
    host_addr_valid || host_data_valid |=> !host_addr_valid && !host_data_valid)
    else $error("host valid too long");
  a_byte_held: assert property (
    cfg_byte_valid && !cfg_byte_ready |=> cfg_byte_valid && $stable(cfg_byte))
    else $error("byte dropped while stalled");
  a_stall_full: assert property (cfg_stall |-> cfg_byte_valid)
    else $error("stall without data");
  c_stall: cover property (cfg_stall);
  c_mux: cover property (host_addr_valid && mode == CFGP_MODE_HOST_MUX);
  c_user: cover property (host_pins_user);
  c_serial_byte: cover property (cfg_byte_valid && !par_mode);
endmodule
bind cfgp_pins cfgp_pins_properties cfgp_pins_properties_i (.clk_sys,
  .reset_n, .cfg_clock, .mode, .data_pin_in, .data_pullup, .cfg_byte,
  .addr_pin_in, .host_addr, .host_byte_enable_n, .host_port_used,
  .cfg_byte_ready, .dout_out, .dout_oe, .host_pins_user, .host_addr_valid,
  .host_data_valid, .cfg_byte_valid, .cfg_stall);
`default_nettype wire

// File: sim/cfgp_source.sv
// Purpose: Serial configuration source driving clock and data.
// Assumes: Clock stands low between bytes; data idles at its pull-up.
// Notes:   The gap argument slows each bit.
`timescale 1ns/1ps
`default_nettype none
module cfgp_source (
  output logic cfg_clock,  // Serial clock.
  output logic serial_data // Serial data line.
);
  initial begin
    cfg_clock = 1'b0;
    serial_data = 1'b1;
  end
  task automatic send_byte(input logic [7:0] value, input int gap_ns);
    for (int i = 7; i >= 0; i--) begin
      serial_data = value[i];
      #(40 + gap_ns) cfg_clock = 1'b1;
      #40 cfg_clock = 1'b0;
    end
    serial_data = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: sim/test_config_and_host_port_pins.sv
// Purpose: Self-checking bench for the configuration pin block.
// Assumes: Host pins held still around each host clock edge.
// Notes:   Serial traffic comes from the source model.
`timescale 1ns/1ps
`default_nettype none
module test_config_and_host_port_pins;
  import cfgp_pkg::*;
  logic clk_sys, reset_n, cfg_start, cfg_done, host_port_used, data_strobe;
  logic host_port_clock, host_addr_strobe, cfg_byte_ready, dout_out, dout_oe;
  logic host_pins_user, host_addr_valid, host_data_valid, cfg_byte_valid;
  logic cfg_stall;
  cfgp_mode_type mode;
  logic [7:0] par_data, data_pullup, host_data, cfg_byte;
  logic [4:0] addr_pin_in, host_addr;
  logic [1:0] host_byte_enable_n;
  wire logic cfg_clock, serial_data;
  wire logic [7:0] data_pin_in;
  int fails, checks_done;
  assign data_pin_in = {par_data[7:1], par_data[0] & serial_data};
  cfgp_source cfgp_source_i (.cfg_clock, .serial_data);
  cfgp_pins cfgp_pins_i (.clk_sys, .reset_n, .mode, .cfg_start, .cfg_done,
    .host_port_used, .cfg_clock, .data_pin_in, .data_strobe, .addr_pin_in,
    .host_byte_enable_n, .host_port_clock, .host_addr_strobe, .data_pullup,
    .dout_out, .dout_oe, .host_pins_user, .host_addr, .host_addr_valid,
    .host_data, .host_data_valid, .cfg_byte, .cfg_byte_valid,
    .cfg_byte_ready, .cfg_stall);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic enter_config(input cfgp_mode_type m);
    @(posedge clk_sys);
    mode <= m;
    cfg_done <= 1'b0;
    cfg_start <= 1'b1;
    @(posedge clk_sys);
    cfg_start <= 1'b0;
    step(1);
    check(dout_oe, 1'b1);
    check(host_pins_user, 1'b0);
  endtask
  task automatic leave_config;
    @(posedge clk_sys);
    cfg_done <= 1'b1;
    step(2);
    check({dout_oe, data_pullup}, 9'h000);
  endtask
  task automatic pop_byte(input logic [7:0] want);
    for (int n = 0; n < 2000 && cfg_byte_valid !== 1'b1; n++) step(1);
    check(cfg_byte_valid, 1'b1);
    check(cfg_byte, want);
    @(posedge clk_sys);
    cfg_byte_ready <= 1'b1;
    @(posedge clk_sys);
    cfg_byte_ready <= 1'b0;
    step(1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_serial(input cfgp_mode_type m, input int count);
    logic [7:0] last_byte;
    enter_config(m);
    check(data_pullup, 8'h01);
    for (int i = 0; i < count; i++)
      cfgp_source_i.send_byte(8'h96 ^ (8'(i) * 8'h1D), (i % 2) * 40);
    step(20);
    check(cfg_stall, count > CFGP_FIFO_DEPTH);
    // The daisy chain lags one byte: it ends on the last kept byte's MSB.
    last_byte = 8'((count > CFGP_FIFO_DEPTH ? CFGP_FIFO_DEPTH : count) - 1);
    last_byte = 8'h96 ^ (last_byte * 8'h1D);
    check(dout_out, last_byte[7]);
    for (int i = 0; i < count && i < CFGP_FIFO_DEPTH; i++)
      pop_byte(8'h96 ^ (8'(i) * 8'h1D));
    step(4);
    check(cfg_byte_valid, 1'b0);
    leave_config();
  endtask
  task automatic t_parallel(input cfgp_mode_type m, input logic [7:0] v);
    enter_config(m);
    check(data_pullup, CFGP_PULLUP_ALL);
    par_data <= v;
    step(2);
    data_strobe <= 1'b1;
    step(4);
    data_strobe <= 1'b0;
    pop_byte(v);
    par_data <= 8'hFF;
    leave_config();
  endtask
  task automatic host_pulse(input logic is_addr, input logic [7:0] want);
    @(posedge clk_sys);
    host_addr_strobe <= is_addr;
    step(4);
    host_port_clock <= 1'b1;
    for (int n = 0; n < 20 && (is_addr ? host_addr_valid : host_data_valid)
         !== 1'b1; n++) step(1);
    check(is_addr ? host_addr_valid : host_data_valid, 1'b1);
    check(is_addr ? {3'h0, host_addr} : host_data, want);
    @(posedge clk_sys);
    host_port_clock <= 1'b0;
    step(4);
  endtask
  task automatic t_host;
    enter_config(CFGP_MODE_HOST_START);
    leave_config();
    check(host_pins_user, 1'b1);
    host_port_used <= 1'b1;
    step(2);
    check(host_pins_user, 1'b0);
    addr_pin_in <= 5'h13;
    host_pulse(1'b1, 8'h13);
    par_data <= 8'hA5;
    host_pulse(1'b0, 8'hA5);
    mode <= CFGP_MODE_HOST_MUX;
    par_data <= 8'h14;
    addr_pin_in <= 5'h0A;
    host_byte_enable_n <= 2'h2;
    host_pulse(1'b1, 8'h15);
    par_data <= 8'h3C;
    host_pulse(1'b0, 8'h3C);
  endtask
  initial begin
    {reset_n, cfg_start, cfg_done, host_port_used, data_strobe} = '0;
    {host_port_clock, host_addr_strobe, cfg_byte_ready} = '0;
    mode = CFGP_MODE_SLAVE_SERIAL;
    par_data = 8'hFF;
    addr_pin_in = CFGP_ADDR_ZERO;
    host_byte_enable_n = CFGP_BE_OFF;
    fails = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_serial(CFGP_MODE_SLAVE_SERIAL, 17);
    t_serial(CFGP_MODE_MASTER_SERIAL, 2);
    t_parallel(CFGP_MODE_MASTER_PARALLEL, 8'h5A);
    t_parallel(CFGP_MODE_PERIPHERAL, 8'hC3);
    t_parallel(CFGP_MODE_SLAVE_PARALLEL, 8'h0F);
    t_host();
    test_done();
  end
  initial begin
    #300000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
